// file: shared/charger_flag_pkg.sv
// Package for the charger event flag latch: register offsets, field positions, carriers.
// Assumes a single system clock and an active-low asynchronous reset.
`default_nettype none
package charger_flag_pkg;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h02;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h01;
  localparam int BIT_SYSMIN_EVT = 5;
  localparam int BIT_INPUT_LOOP_EVT = 4;
  localparam int BIT_THERMAL_EVT = 3;
  localparam int BIT_INPUT_DETAIL_EVT = 2;
  localparam int BIT_CHARGER_EVT = 1;
  localparam int BIT_THERMISTOR_EVT = 0;
  localparam int BIT_INPUT_MIN_V = 6;
  localparam int BIT_INPUT_ILIM = 5;
  localparam int BIT_SYSMIN = 4;
  localparam int BIT_THERMAL = 3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam int INPUT_DETAIL_W = 2;
  localparam int CHARGER_DETAIL_W = 4;
  localparam int THERMISTOR_DETAIL_W = 3;

  typedef struct packed {
    logic sysmin_loop_active;
    logic input_min_voltage_loop_active;
    logic input_current_limit_active;
    logic thermal_reg_active;
    logic [INPUT_DETAIL_W-1:0] input_detail;
    logic [CHARGER_DETAIL_W-1:0] charger_state_detail;
    logic [THERMISTOR_DETAIL_W-1:0] thermistor_detail;
  } charger_status_t;

  localparam int STATUS_W = $bits(charger_status_t);
  localparam logic [STATUS_W-1:0] STATUS_RESET = '0;
endpackage : charger_flag_pkg
`default_nettype wire

// file: hdl/status_sync.sv
// Two-flop synchroniser for the analogue-side status bits.
// Assumes inputs come from outside the system clock domain.
`default_nettype none
module status_sync #(
  parameter int WIDTH = 13
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // A zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_width_check
    $error("status_sync WIDTH must be at least 1");
  end

  always_comb begin
    meta_d = i_ce ? i_async : meta_q;
    sync_d = i_ce ? meta_q : sync_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule : status_sync
`default_nettype wire

// file: hdl/charger_event_flag_latch.sv
// Latched change flags for the charger and power-path status, cleared by reading them.
// Assumes a simple synchronous register read port in the system clock domain.
// How it works
// - Flag bit 5 sets whenever the minimum-system-voltage loop status changes.
// - Flag bit 4 sets when input min-voltage or current-limit loop status changes.
// - Flag bit 3 sets when the thermal-regulation status rises or falls; holds until read.
// - Flag bit 3 follows every transition of the thermal-regulation status bit.
// - Flag bit 2 sets when the two-bit input detail field changes value.
// - Flag bit 1 sets when the four-bit charger detail field changes value.
// - Flag bit 0 sets when the three-bit thermistor detail field changes value.
`default_nettype none
module charger_event_flag_latch
  import charger_flag_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire charger_flag_pkg::charger_status_t i_status,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [7:0] o_event_flags
);
  import charger_flag_pkg::*;

  charger_status_t sync_w;
  charger_status_t prev_q;
  charger_status_t prev_d;
  logic primed_q;
  logic primed_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic [7:0] events;
  logic [7:0] live;

  function automatic logic changed(input logic [3:0] a, input logic [3:0] b);
    changed = (a != b);
  endfunction : changed

  status_sync #(.WIDTH(STATUS_W)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async(i_status),
    .o_sync(sync_w)
  );

  always_comb begin
    events = 8'h00;
    // No events until a reference sample exists, so reset does not look like a change
    if (primed_q) begin
      events[BIT_SYSMIN_EVT] = sync_w.sysmin_loop_active ^ prev_q.sysmin_loop_active;
      events[BIT_INPUT_LOOP_EVT] =
        (sync_w.input_min_voltage_loop_active ^ prev_q.input_min_voltage_loop_active) |
        (sync_w.input_current_limit_active ^ prev_q.input_current_limit_active);
      // Both edges count: the flag marks any change of the regulation status
      events[BIT_THERMAL_EVT] = sync_w.thermal_reg_active ^ prev_q.thermal_reg_active;
      events[BIT_INPUT_DETAIL_EVT] = changed({2'h0, sync_w.input_detail},
                                             {2'h0, prev_q.input_detail});
      events[BIT_CHARGER_EVT] = changed(sync_w.charger_state_detail,
                                        prev_q.charger_state_detail);
      events[BIT_THERMISTOR_EVT] = changed({1'b0, sync_w.thermistor_detail},
                                           {1'b0, prev_q.thermistor_detail});
    end
    live = 8'h00;
    live[BIT_INPUT_MIN_V] = sync_w.input_min_voltage_loop_active;
    live[BIT_INPUT_ILIM] = sync_w.input_current_limit_active;
    live[BIT_SYSMIN] = sync_w.sysmin_loop_active;
    live[BIT_THERMAL] = sync_w.thermal_reg_active;
    live[THERMISTOR_DETAIL_W-1:0] = sync_w.thermistor_detail;
  end

  always_comb begin
    prev_d = prev_q;
    primed_d = primed_q;
    flags_d = flags_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    if (i_ce) begin
      prev_d = sync_w;
      primed_d = 1'b1;
      rd_valid_d = i_rd_en;
      if (i_rd_en) begin
        case (i_rd_addr)
          ADDR_EVENT_FLAGS: begin
            rd_data_d = flags_q;
            // Read clears all; a same-cycle event re-sets its bit
            flags_d = events;
          end
          ADDR_LIVE_STATUS: begin
            rd_data_d = live;
            flags_d = flags_q | events;
          end
          default: begin
            rd_data_d = 8'h00;
            flags_d = flags_q | events;
          end
        endcase
      end else begin
        flags_d = flags_q | events;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= STATUS_RESET;
      primed_q <= 1'b0;
      flags_q <= FLAGS_RESET;
      rd_data_q <= READ_DATA_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      primed_q <= primed_d;
      flags_q <= flags_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_event_flags = flags_q;
endmodule : charger_event_flag_latch
`default_nettype wire

// file: dv/flag_latch_properties.sv
// Port checker for the charger event flag latch.
// Assumes checks pause while the clock enable is low, since all state except the read-valid flag is frozen then.
`default_nettype none
module flag_latch_properties
  import charger_flag_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire charger_flag_pkg::charger_status_t i_status,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_event_flags
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n || !i_ce);
  // Range covers the two synchroniser flops plus the flag register
  sysmin_flag_a: assert property ($changed(i_status.sysmin_loop_active) |->
    ##[2:4] o_event_flags[5]) else $error("sysmin flag");
  input_loop_a: assert property ($changed(i_status.input_min_voltage_loop_active) ||
    $changed(i_status.input_current_limit_active) |-> ##[2:4] o_event_flags[4]) else $error("loop");
  thermal_rise_a: assert property ($rose(i_status.thermal_reg_active) |->
    ##[2:4] o_event_flags[3]) else $error("thermal rise");
  thermal_fall_a: assert property ($fell(i_status.thermal_reg_active) |->
    ##[2:4] o_event_flags[3]) else $error("thermal fall");
  input_detail_a: assert property ($changed(i_status.input_detail) |->
    ##[2:4] o_event_flags[2]) else $error("input detail");
  charger_detail_a: assert property ($changed(i_status.charger_state_detail) |->
    ##[2:4] o_event_flags[1]) else $error("charger detail");
  thermistor_flag_a: assert property ($changed(i_status.thermistor_detail) |->
    ##[2:4] o_event_flags[0]) else $error("thermistor");
  flag_hold_a: assert property (o_event_flags[0] && !i_rd_en |=> o_event_flags[0])
    else $error("flag dropped");
endmodule : flag_latch_properties
`default_nettype wire

// file: dv/charger_event_flag_latch_tb.sv
// Bench for the charger event flag latch: flag and status reads.
// Assumes the checker is bound here.
`default_nettype none
module charger_event_flag_latch_tb;
  import charger_flag_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, ce = 1, rd_en = 0, rd_valid;
  logic [7:0] rd_addr = 8'h00, rd_data, flags, d1, d2;
  charger_status_t st = '0;
  int err_count = 0, compares = 0;
  logic [12:0] mk [8] = '{13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0200, 13'h0180,
    13'h0040, 13'h0001};
  logic [7:0] ex [8] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h01};
  charger_event_flag_latch charger_event_flag_latch_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_ce(ce), .i_status(st), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_event_flags(flags));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk({7'h00, rd_valid}, 8'h01);
    d = rd_data;
  endtask : rd
  task automatic tally_and_finish();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h01, d1);
    chk(d1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      st <= charger_status_t'(st ^ mk[i]);
      repeat (6) @(posedge clk);
      #1 chk(flags, ex[i]);
      rd(8'h01, d1);
      rd(8'h01, d2);
      chk(d1, ex[i]);
      chk(d2, 8'h00);
      chk(flags, 8'h00);
    end
    $display("single events done");
    // Sweep the read across the event's arrival; the event must show in one of the reads
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      st <= charger_status_t'(st ^ 13'h0001);
      repeat (k) @(posedge clk);
      rd(8'h01, d1);
      repeat (6) @(posedge clk);
      rd(8'h01, d2);
      chk(d1 | d2, 8'h01);
    end
    $display("read race done");
    // Enable low freezes the synchroniser, so the change only lands once it returns
    @(posedge clk);
    ce <= 1'b0;
    st <= charger_status_t'(st ^ 13'h0001);
    repeat (6) @(posedge clk);
    #1 chk(flags, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(flags, 8'h01);
    rd(8'h01, d1);
    chk(d1, 8'h01);
    $display("clock enable done");
    rd(8'h05, d1);
    chk(d1, 8'h00);
    rd(8'h02, d1);
    chk(d1, 8'h71);
    tally_and_finish();
  end
endmodule : charger_event_flag_latch_tb
bind charger_event_flag_latch flag_latch_properties flag_latch_properties_inst (.*);
`default_nettype wire
